/* File: inc/pinctl_pkg.sv */
// Register map, field widths and reset values of the pin control block
package pinctl_pkg;
   // Pin groups packed into one vector: port0 [3:0], port1 [11:4],
   // port3 [15:12], port12 [16]
   localparam int P0_W = 4;
   localparam int P1_W = 8;
   localparam int P3_W = 4;
   localparam int P12_W = 1;
   localparam int BIDIR_W = 17;
   localparam int P2_W = 4;
   localparam int IRQ_N = 6;
   // Bit positions inside the packed vector
   localparam int P0_LSB = 0;
   localparam int P1_LSB = 4;
   localparam int P3_LSB = 12;
   localparam int P12_LSB = 16;
   localparam int TMR16_CLK_BIT = 0;
   localparam int TMR16_CAP_BIT = 1;
   localparam int TMR8_CLK_BIT = 11;
   localparam int IRQ_F_BIT = 10;
   // Byte offsets on the bus
   localparam logic [7:0] P0_DATA_OFS = 8'h00;
   localparam logic [7:0] P0_DIR_OFS = 8'h04;
   localparam logic [7:0] P0_PULL_OFS = 8'h08;
   localparam logic [7:0] P0_FUNC_OFS = 8'h0C;
   localparam logic [7:0] P1_DATA_OFS = 8'h10;
   localparam logic [7:0] P1_DIR_OFS = 8'h14;
   localparam logic [7:0] P1_PULL_OFS = 8'h18;
   localparam logic [7:0] P1_FUNC_OFS = 8'h1C;
   localparam logic [7:0] P3_DATA_OFS = 8'h20;
   localparam logic [7:0] P3_DIR_OFS = 8'h24;
   localparam logic [7:0] P3_PULL_OFS = 8'h28;
   localparam logic [7:0] P3_FUNC_OFS = 8'h2C;
   localparam logic [7:0] P12_DATA_OFS = 8'h30;
   localparam logic [7:0] P12_DIR_OFS = 8'h34;
   localparam logic [7:0] P12_PULL_OFS = 8'h38;
   localparam logic [7:0] P12_FUNC_OFS = 8'h3C;
   localparam logic [7:0] P2_DATA_OFS = 8'h40;
   localparam logic [7:0] P2_FUNC_OFS = 8'h44;
   localparam logic [7:0] P13_DATA_OFS = 8'h48;
   localparam logic [7:0] IRQ_RISE_OFS = 8'h4C;
   localparam logic [7:0] IRQ_FALL_OFS = 8'h50;
   // Reset values: direction 1 = input
   localparam logic [BIDIR_W-1:0] DIR_RST = 17'h1_FFFF;
   localparam logic [BIDIR_W-1:0] VEC_RST = 17'h0_0000;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   // Bus phase of the slave
   typedef enum logic {ph_idle, ph_busy} bus_phase_t;
endpackage

/* File: src/port_pin_function_control.sv */
// Port pin direction, pull-up, function select and edge detect logic
// Behaviour
// - Port0 four bits, per-bit direction register
// - Port0 pull-ups per bit from register
// - Port1 eight bits, per-bit direction register
// - Port1 pull-ups per bit from register
// - Port2 four bits, input only, readable
// - Port3 four bits, per-bit direction register
// - Port3 pull-ups per bit from register
// - Port12 single bit, own direction register
// - Port12 pull-up from own register
// - Port13 single bit, always driving output
// - Each bidirectional pin selectable: port or peripheral
// - External interrupts on rising, falling, both
// - Active-low reset holds whole block
// - Timer pins route to clock, captures
// - Timer and serial pins input after reset
// - Port2 control mode feeds analog channels
// - Reset: bidirectional inputs, output bit output
`timescale 1ns/10ps
`default_nettype none
module port_pin_function_control
   import pinctl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [BIDIR_W-1:0] bidir_pin_in,
   output logic [BIDIR_W-1:0] bidir_pin_out,
   output logic [BIDIR_W-1:0] bidir_pin_oe,
   output logic [BIDIR_W-1:0] bidir_pullup_en,
   input wire logic [P2_W-1:0] port2_pin_in,
   output logic [P2_W-1:0] analog_in_en,
   output logic output_only_bit,
   input wire logic [BIDIR_W-1:0] periph_out,
   output logic [BIDIR_W-1:0] periph_in,
   output logic [IRQ_N-1:0] ext_irq_pulse,
   output logic timer16_count_in,
   output logic [1:0] capture_reg_a_trig,
   output logic capture_reg_b_trig,
   output logic timer8_clk_in
);
   // Bus phase and captured address phase
   bus_phase_t phase;
   bus_phase_t next_phase;
   logic [7:0] addr_q;
   logic write_q;
   logic [31:0] rdata_mux;
   // Software state
   logic [P0_W-1:0] port0_direction_reg;
   logic [P0_W-1:0] port0_pullup_reg;
   logic [P1_W-1:0] port1_direction_reg;
   logic [P1_W-1:0] port1_pullup_reg;
   logic [P3_W-1:0] port3_direction_reg;
   logic [P3_W-1:0] port3_pullup_reg;
   logic [P12_W-1:0] port12_direction_reg;
   logic [P12_W-1:0] port12_pullup_reg;
   logic [BIDIR_W-1:0] out_latch; // Output data latches
   logic [BIDIR_W-1:0] func_sel; // 1 = peripheral function
   logic [P2_W-1:0] port2_func; // 1 = analog channel
   logic [IRQ_N-1:0] irq_rise_en;
   logic [IRQ_N-1:0] irq_fall_en;
   // Sampled pins and previous interrupt levels
   logic [BIDIR_W-1:0] pin_sample;
   logic [P2_W-1:0] port2_sample;
   logic [IRQ_N-1:0] irq_prev;

   // Address phase accepted only when the bus is ready
   wire logic take = hsel & htrans[1] & hready;
   wire logic busy = (phase == ph_busy);
   wire logic wr = busy & write_q;
   wire logic rd = busy & ~write_q;
   assign next_phase = take ? ph_busy : ph_idle;

   // Packed views of the per-port registers
   wire logic [BIDIR_W-1:0] dir_all = {port12_direction_reg,
      port3_direction_reg, port1_direction_reg, port0_direction_reg};
   wire logic [BIDIR_W-1:0] pull_all = {port12_pullup_reg,
      port3_pullup_reg, port1_pullup_reg, port0_pullup_reg};

   // Pin drive: latch or peripheral, direction decides enable
   wire logic [BIDIR_W-1:0] next_pin_out =
      (func_sel & periph_out) | (~func_sel & out_latch);
   wire logic [BIDIR_W-1:0] next_pin_oe = ~dir_all;
   // Pull-up gated by input direction, so it never fights a driver
   wire logic [BIDIR_W-1:0] next_pullup = pull_all & dir_all;
   // Read view: pin when input, latch when output
   wire logic [BIDIR_W-1:0] pin_view =
      (dir_all & pin_sample) | (~dir_all & out_latch);
   // Analog bits read as zero in port mode readback
   wire logic [P2_W-1:0] port2_view = port2_sample & ~port2_func;

   // Interrupt sources: [0] on port12, [4:1] on port3, [5] on port1
   wire logic [IRQ_N-1:0] irq_src = {pin_sample[IRQ_F_BIT],
      pin_sample[P3_LSB+P3_W-1:P3_LSB], pin_sample[P12_LSB]};
   wire logic [IRQ_N-1:0] irq_on = {func_sel[IRQ_F_BIT],
      func_sel[P3_LSB+P3_W-1:P3_LSB], func_sel[P12_LSB]};
   wire logic [IRQ_N-1:0] next_irq = irq_on &
      ((irq_src & ~irq_prev & irq_rise_en) |
       (~irq_src & irq_prev & irq_fall_en));

   // Bus phase, whole block held while reset is low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase <= ph_idle;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         phase <= next_phase;
         hreadyout <= (next_phase == ph_idle);
         hresp <= 1'b0; // Always OKAY
      end
   end

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= 8'h00;
         write_q <= 1'b0;
      end else if (take) begin
         addr_q <= haddr[7:0];
         write_q <= hwrite;
      end
   end

   // Read data loaded in the wait cycle, after any earlier write landed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= WORD_RST;
      end else if (rd) begin
         hrdata <= rdata_mux;
      end
   end

   // Register writes; unmapped offsets are ignored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {port12_direction_reg, port3_direction_reg,
          port1_direction_reg, port0_direction_reg} <= DIR_RST;
         {port12_pullup_reg, port3_pullup_reg,
          port1_pullup_reg, port0_pullup_reg} <= VEC_RST;
         out_latch <= VEC_RST;
         func_sel <= VEC_RST;
         port2_func <= 4'h0;
         output_only_bit <= 1'b0;
         irq_rise_en <= 6'h00;
         irq_fall_en <= 6'h00;
      end else if (wr) begin
         case (addr_q)
            P0_DATA_OFS: out_latch[3:0] <= hwdata[3:0];
            P0_DIR_OFS: port0_direction_reg <= hwdata[3:0];
            P0_PULL_OFS: port0_pullup_reg <= hwdata[3:0];
            P0_FUNC_OFS: func_sel[3:0] <= hwdata[3:0];
            P1_DATA_OFS: out_latch[11:4] <= hwdata[7:0];
            P1_DIR_OFS: port1_direction_reg <= hwdata[7:0];
            P1_PULL_OFS: port1_pullup_reg <= hwdata[7:0];
            P1_FUNC_OFS: func_sel[11:4] <= hwdata[7:0];
            P3_DATA_OFS: out_latch[15:12] <= hwdata[3:0];
            P3_DIR_OFS: port3_direction_reg <= hwdata[3:0];
            P3_PULL_OFS: port3_pullup_reg <= hwdata[3:0];
            P3_FUNC_OFS: func_sel[15:12] <= hwdata[3:0];
            P12_DATA_OFS: out_latch[16] <= hwdata[0];
            P12_DIR_OFS: port12_direction_reg <= hwdata[0:0];
            P12_PULL_OFS: port12_pullup_reg <= hwdata[0:0];
            P12_FUNC_OFS: func_sel[16] <= hwdata[0];
            P2_FUNC_OFS: port2_func <= hwdata[3:0];
            P13_DATA_OFS: output_only_bit <= hwdata[0];
            IRQ_RISE_OFS: irq_rise_en <= hwdata[5:0];
            IRQ_FALL_OFS: irq_fall_en <= hwdata[5:0];
            default: begin
               // Unmapped or read-only: no effect
            end
         endcase
      end
   end

   // Read multiplexer, unmapped reads return zero
   always_comb begin
      rdata_mux = WORD_RST;
      case (addr_q)
         P0_DATA_OFS: rdata_mux[3:0] = pin_view[3:0];
         P0_DIR_OFS: rdata_mux[3:0] = port0_direction_reg;
         P0_PULL_OFS: rdata_mux[3:0] = port0_pullup_reg;
         P0_FUNC_OFS: rdata_mux[3:0] = func_sel[3:0];
         P1_DATA_OFS: rdata_mux[7:0] = pin_view[11:4];
         P1_DIR_OFS: rdata_mux[7:0] = port1_direction_reg;
         P1_PULL_OFS: rdata_mux[7:0] = port1_pullup_reg;
         P1_FUNC_OFS: rdata_mux[7:0] = func_sel[11:4];
         P3_DATA_OFS: rdata_mux[3:0] = pin_view[15:12];
         P3_DIR_OFS: rdata_mux[3:0] = port3_direction_reg;
         P3_PULL_OFS: rdata_mux[3:0] = port3_pullup_reg;
         P3_FUNC_OFS: rdata_mux[3:0] = func_sel[15:12];
         P12_DATA_OFS: rdata_mux[0] = pin_view[16];
         P12_DIR_OFS: rdata_mux[0] = port12_direction_reg[0];
         P12_PULL_OFS: rdata_mux[0] = port12_pullup_reg[0];
         P12_FUNC_OFS: rdata_mux[0] = func_sel[16];
         P2_DATA_OFS: rdata_mux[3:0] = port2_view;
         P2_FUNC_OFS: rdata_mux[3:0] = port2_func;
         P13_DATA_OFS: rdata_mux[0] = output_only_bit;
         IRQ_RISE_OFS: rdata_mux[5:0] = irq_rise_en;
         IRQ_FALL_OFS: rdata_mux[5:0] = irq_fall_en;
         default: rdata_mux = WORD_RST;
      endcase
   end

   // Pin sampling; inputs are synchronous so one stage suffices
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_sample <= VEC_RST;
         port2_sample <= 4'h0;
         irq_prev <= 6'h00;
      end else begin
         pin_sample <= bidir_pin_in;
         port2_sample <= port2_pin_in;
         irq_prev <= irq_src;
      end
   end

   // Registered pin controls; reset leaves every bidirectional pin an input
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bidir_pin_out <= VEC_RST;
         bidir_pin_oe <= VEC_RST;
         bidir_pullup_en <= VEC_RST;
         analog_in_en <= 4'h0;
      end else begin
         bidir_pin_out <= next_pin_out;
         bidir_pin_oe <= next_pin_oe;
         bidir_pullup_en <= next_pullup;
         analog_in_en <= port2_func;
      end
   end

   // Peripheral inputs and interrupt pulses
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         periph_in <= VEC_RST;
         ext_irq_pulse <= 6'h00;
         timer16_count_in <= 1'b0;
         capture_reg_a_trig <= 2'b00;
         capture_reg_b_trig <= 1'b0;
         timer8_clk_in <= 1'b0;
      end else begin
         periph_in <= pin_sample & func_sel;
         ext_irq_pulse <= next_irq;
         // First timer pin: counter clock and both captures
         timer16_count_in <= pin_sample[TMR16_CLK_BIT] &
            func_sel[TMR16_CLK_BIT];
         capture_reg_b_trig <= pin_sample[TMR16_CLK_BIT] &
            func_sel[TMR16_CLK_BIT];
         capture_reg_a_trig <= pin_sample[1:0] & func_sel[1:0];
         timer8_clk_in <= pin_sample[TMR8_CLK_BIT] &
            func_sel[TMR8_CLK_BIT];
      end
   end

   // Checks on the behaviour above
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_bus_one_wait: assert property (
      take |=> !hreadyout ##1 hreadyout)
      else $error("bus answer not after one wait cycle");
   a_dir_read_back: assert property (
      take && !hwrite && haddr[7:0] == P0_DIR_OFS
      |=> ##1 hrdata[3:0] == port0_direction_reg)
      else $error("direction readback mismatch");
   a_oe_from_dir: assert property (
      $changed(port1_direction_reg)
      |=> bidir_pin_oe[11:4] == ~port1_direction_reg)
      else $error("output enable not following direction");
   a_pull_when_input: assert property (
      (bidir_pullup_en & bidir_pin_oe) == VEC_RST)
      else $error("pull-up active on driven pin");
   a_pull_select: assert property (
      ##1 bidir_pullup_en[15:12] ==
      $past(port3_pullup_reg & port3_direction_reg))
      else $error("port3 pull-up wrong");
   a_analog_read_zero: assert property (
      take && !hwrite && haddr[7:0] == P2_DATA_OFS
      |=> ##1 (hrdata[3:0] & port2_func) == 4'h0)
      else $error("analog bit read as port data");
   a_irq_rise_pulse: assert property (
      $rose(irq_src[0]) && irq_rise_en[0] && irq_on[0]
      |=> ext_irq_pulse[0])
      else $error("rising edge interrupt missed");
   a_irq_no_cause: assert property (
      ext_irq_pulse[1] |-> $past(irq_on[1]) &&
      ($past(irq_rise_en[1]) || $past(irq_fall_en[1])))
      else $error("interrupt without enabled edge");
   a_reset_inputs: assert property (
      $past(!hresetn) |-> bidir_pin_oe == VEC_RST)
      else $error("pin driven right after reset");
   a_timer_route: assert property (
      timer16_count_in |-> capture_reg_b_trig && capture_reg_a_trig[0])
      else $error("first timer pin not on all three");
   a_latch_drive: assert property (
      ##1 bidir_pin_out[2] == ($past(func_sel[2]) ?
      $past(periph_out[2]) : $past(out_latch[2])))
      else $error("pin output source wrong");

   c_write: cover property (take && hwrite ##2 hreadyout);
   c_read: cover property (take && !hwrite ##2 hreadyout);
   c_irq: cover property (|ext_irq_pulse);
   c_analog: cover property (|analog_in_en);
endmodule
`default_nettype wire

/* File: tb/pin_board.sv */
// Board model that resolves the level seen on each bidirectional pin
`timescale 1ns/10ps
`default_nettype none
module pin_board
   import pinctl_pkg::*;
(
   input wire logic [BIDIR_W-1:0] pin_out,
   input wire logic [BIDIR_W-1:0] pin_oe,
   input wire logic [BIDIR_W-1:0] pullup_en,
   input wire logic [BIDIR_W-1:0] ext_level,
   output logic [BIDIR_W-1:0] pin_level
);
   // Device driver wins, then the pull-up, then the board source
   always_comb begin
      for (int i = 0; i < BIDIR_W; i++) begin
         if (pin_oe[i]) begin
            pin_level[i] = pin_out[i];
         end else if (pullup_en[i]) begin
            pin_level[i] = 1'b1;
         end else begin
            pin_level[i] = ext_level[i];
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/port_pin_function_control_tb.sv */
// Self-checking bench for the pin control block over AHB-Lite
`timescale 1ns/10ps
`default_nettype none
module port_pin_function_control_tb;
   import pinctl_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [BIDIR_W-1:0] pin_in, pin_out, pin_oe, pull_en, ext, po, per_in;
   logic [P2_W-1:0] p2, an_en;
   logic [IRQ_N-1:0] irq;
   logic obit, t16, cap_b, t8, rd_wait;
   logic [1:0] cap_a;
   logic [31:0] exq[$];
   logic [31:0] m, d, dir, pu, f, pe, pp, ie, seed;
   int n_fail, checked, n_irq, w[4], l[4];
   port_pin_function_control dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .bidir_pin_in(pin_in), .bidir_pin_out(pin_out),
      .bidir_pin_oe(pin_oe), .bidir_pullup_en(pull_en),
      .port2_pin_in(p2), .analog_in_en(an_en), .output_only_bit(obit),
      .periph_out(po), .periph_in(per_in), .ext_irq_pulse(irq),
      .timer16_count_in(t16), .capture_reg_a_trig(cap_a),
      .capture_reg_b_trig(cap_b), .timer8_clk_in(t8));
   pin_board board (.pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_en(pull_en), .ext_level(ext), .pin_level(pin_in));
   // Free running 100 MHz clock from an outside source, 10 ns period
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // One comparison, counted
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Verdict and end of run
   task automatic test_done;
      // Any reads whose answers never came count together as one mismatch
      if (exq.size() > 0) begin
         n_fail++;
         $display("BAD %0t %0d reads never answered", $time, exq.size());
      end
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Single AHB transfer; waits on hready, never on a fixed count
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] v);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h00_0000, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= v;
      rd_wait <= ~wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_wait <= 1'b0;
   endtask
   // Read: note the expected word, the monitor compares it
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exq.push_back(e);
      bus(1'b0, a, 32'h0000_0000);
   endtask
   // Read data are judged at the edge that ends the data phase
   always @(posedge hclk) begin
      if (rd_wait && hreadyout === 1'b1 && exq.size() > 0)
         cmp(hrdata, exq.pop_front());
   end
   // Pulses on the port12 and first port3 interrupt lines, both counted
   always @(posedge hclk) begin
      if (irq[0] === 1'b1) n_irq++;
      if (irq[1] === 1'b1) n_irq++;
   end
   // Hang guard, far beyond the few hundred cycles needed
   initial begin
      #100us;
      n_fail++;
      $display("BAD %0t watchdog expired", $time);
      test_done();
   end
   // Main sequence
   initial begin
      seed = 32'h149f;
      w = '{4, 8, 4, 1};
      l = '{0, 4, 12, 16};
      {hresetn, hsel, hwrite, rd_wait, htrans} = '0;
      {haddr, hwdata, ext, po, p2} = '0;
      hsize = 3'b010;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      cmp(32'(pin_oe), 32'h0000_0000);
      cmp(32'(pull_en), 32'h0000_0000);
      // Each bidirectional port: random latch, direction, pull, function
      for (int p = 0; p < 4; p++) begin
         m = (32'h1 << w[p]) - 1;
         rd(8'(p * 16 + 4), m);
         d = $random(seed) & m;
         dir = $random(seed) & m;
         pu = $random(seed) & m;
         f = $random(seed) & m;
         pe = $random(seed);
         pp = $random(seed);
         ext <= 17'(pe);
         po <= 17'(pp);
         bus(1'b1, 8'(p * 16), d);
         bus(1'b1, 8'(p * 16 + 4), dir);
         bus(1'b1, 8'(p * 16 + 8), pu);
         bus(1'b1, 8'(p * 16 + 12), f);
         repeat (3) @(posedge hclk);
         pe = ((pe >> l[p]) | pu) & dir & m;
         pp = (pp >> l[p]) & m;
         cmp(32'(pin_oe >> l[p]) & m,
             ~dir & m);
         cmp(32'(pull_en >> l[p]) & m,
             pu & dir);
         cmp(32'(pin_out >> l[p]) & ~dir & m,
             ((f & pp) | (~f & d)) & ~dir & m);
         cmp(32'(per_in >> l[p]) & dir, pe & f);
         rd(8'(p * 16), pe | (d & ~dir));
      end
      // Timer inputs on port0 bits 0 and 1 and port1 bit 7
      bus(1'b1, P0_DIR_OFS, 32'h0000_000F);
      bus(1'b1, P0_PULL_OFS, 32'h0000_0000);
      bus(1'b1, P0_FUNC_OFS, 32'h0000_0003);
      bus(1'b1, P1_DIR_OFS, 32'h0000_00FF);
      bus(1'b1, P1_PULL_OFS, 32'h0000_0000);
      bus(1'b1, P1_FUNC_OFS, 32'h0000_0080);
      for (int v = 0; v < 4; v++) begin
         ext <= 17'(v) | (17'(v & 1) << TMR8_CLK_BIT);
         repeat (4) @(posedge hclk);
         cmp(32'(t16), v & 1);
         cmp(32'(cap_a), v);
         cmp(32'(cap_b), v & 1);
         cmp(32'(t8), v & 1);
      end
      // Edge modes on port12 and port3 bit 0: none, rising, falling, both
      bus(1'b1, P12_DIR_OFS, 32'h0000_0001);
      bus(1'b1, P12_PULL_OFS, 32'h0000_0000);
      bus(1'b1, P12_FUNC_OFS, 32'h0000_0001);
      bus(1'b1, P3_DIR_OFS, 32'h0000_000F);
      bus(1'b1, P3_PULL_OFS, 32'h0000_0000);
      bus(1'b1, P3_FUNC_OFS, 32'h0000_0001);
      for (int md = 0; md < 4; md++) begin
         bus(1'b1, IRQ_RISE_OFS, 32'((md & 1) * 3));
         bus(1'b1, IRQ_FALL_OFS, 32'((md >> 1) * 3));
         n_irq = 0;
         ext <= ext | 17'h1_1000;
         repeat (5) @(posedge hclk);
         cmp(32'(n_irq), 2 * (md & 1));
         ext <= ext & ~17'h1_1000;
         repeat (5) @(posedge hclk);
         cmp(32'(n_irq), 2 * ((md & 1) + (md >> 1)));
      end
      // Input-only port, then handed to the analog channels
      ie = $random(seed) & 32'h0000_000F;
      p2 <= 4'(ie);
      repeat (3) @(posedge hclk);
      rd(P2_DATA_OFS, ie);
      bus(1'b1, P2_FUNC_OFS, 32'h0000_000F);
      repeat (2) @(posedge hclk);
      cmp(32'(an_en), 32'h0000_000F);
      rd(P2_DATA_OFS, 32'h0000_0000);
      // Output-only bit and an unmapped place
      bus(1'b1, P13_DATA_OFS, 32'h0000_0001);
      repeat (2) @(posedge hclk);
      cmp(32'(obit), 32'h0000_0001);
      rd(P13_DATA_OFS, 32'h0000_0001);
      rd(8'h80, 32'h0000_0000);
      // Response code is OKAY after the last transfer
      cmp(32'(hresp), 32'h0000_0000);
      // Reset in mid-run acts at once, without a clock edge
      @(posedge hclk);
      hresetn <= 1'b0;
      #2;
      cmp(32'(pin_oe), 32'h0000_0000);
      cmp(32'(obit), 32'h0000_0000);
      @(posedge hclk);
      hresetn <= 1'b1;
      // Port3 direction was last written 0xF before the reset; must read all input
      rd(P3_DIR_OFS, 32'h0000_000F);
      repeat (2) @(posedge hclk);
      test_done();
   end
endmodule
`default_nettype wire
